// ==== include/entry_pkg.sv ====
// Purpose: Shared constants and types for the register-entry sequence link.
// Assumes: 22-bit address, 16-bit data, asynchronous cycles sampled by CLK.
// Notes: Control registers are 22 bits wide; only the low 16 bits are reachable.
package entry_pkg;
	localparam int ADDR_W = 22;
	localparam int DATA_W = 16;
	localparam int REG_W = 22;
	localparam logic [ADDR_W-1:0] TOP_ADDR = 22'h3F_FFFF;
	localparam logic [DATA_W-1:0] SEL_REFRESH = 16'h0000;
	localparam logic [DATA_W-1:0] SEL_BUS = 16'h0001;
	localparam logic [DATA_W-1:0] SEL_IDENT = 16'h0002;
	localparam logic [REG_W-1:0] REFRESH_RESET = 22'h00_0000;
	localparam logic [REG_W-1:0] BUS_RESET = 22'h00_0000;
	// Identification value is arbitrary.
	localparam logic [REG_W-1:0] IDENT_VALUE = 22'h00_1234;
	// Host phase lengths in CLK cycles: select low time and high gap.
	// The low time must outlast the memory's input filter delay, or a read samples the bus before it is driven.
	localparam logic [3:0] ACCESS_CYCLES = 4'h6;
	localparam logic [3:0] GAP_CYCLES = 4'h2;
	typedef enum logic [1:0] {TGT_REFRESH = 2'b00, TGT_BUS = 2'b01, TGT_IDENT = 2'b10, TGT_NONE = 2'b11} target_type;
	typedef enum logic [2:0] {DET_IDLE = 3'b000, DET_READ1 = 3'b001, DET_READ2 = 3'b011,
		DET_SELECT = 3'b010, DET_FINAL = 3'b110} det_state_type;
	function automatic target_type decode_target(input logic [DATA_W-1:0] value);
		if (value == SEL_REFRESH)
		begin
			return TGT_REFRESH;
		end
		if (value == SEL_BUS)
		begin
			return TGT_BUS;
		end
		if (value == SEL_IDENT)
		begin
			return TGT_IDENT;
		end
		return TGT_NONE;
	endfunction : decode_target
endpackage : entry_pkg

// ==== include/entry_if.sv ====
// Purpose: Asynchronous parallel bus between the host controller and the memory.
// Assumes: The testbench resolves the data wire from the two enables.
// Notes: Output enables are active low; a low enable means that end drives data.
`timescale 1ns/1ps
interface entry_if;
	import entry_pkg::*;
	logic select_n;
	logic write_n;
	logic output_en_n;
	logic address_valid_n;
	logic bus_clk;
	logic [ADDR_W-1:0] addr;
	logic [DATA_W-1:0] host_dq_out;
	logic host_dq_oe_n;
	logic [DATA_W-1:0] mem_dq_out;
	logic mem_dq_oe_n;
	logic [DATA_W-1:0] dq_in;
	modport host (output select_n, write_n, output_en_n, address_valid_n, bus_clk, addr,
		host_dq_out, host_dq_oe_n, input dq_in);
	modport mem (input select_n, write_n, output_en_n, address_valid_n, bus_clk, addr, dq_in,
		output mem_dq_out, mem_dq_oe_n);
endinterface : entry_if

// ==== hw/pin_sync.sv ====
// Purpose: Three-stage synchroniser with agreement filter for pin inputs.
// Assumes: Input is asynchronous to CLK.
// Notes: The first stage is read only by the second stage.
`timescale 1ns/1ps
module pin_sync #(parameter int W = 1, parameter logic [W-1:0] INIT = '0)
(
	// Clock and reset
	input wire logic CLK,
	input wire logic RST,
	// Pin and filtered level
	input wire logic [W-1:0] PIN,
	output logic [W-1:0] LEVEL
);
	logic [W-1:0] stage1;
	logic [W-1:0] stage2;
	logic [W-1:0] stage3;
	logic [W-1:0] next_level;

	always_comb
	begin
		next_level = LEVEL;
		if (stage2 == stage3)
		begin
			next_level = stage3;
		end
	end

	always_ff @(posedge CLK)
	begin
		if (RST)
		begin
			stage1 <= INIT;
			stage2 <= INIT;
			stage3 <= INIT;
			LEVEL <= INIT;
		end
		else
		begin
			stage1 <= PIN;
			stage2 <= stage1;
			stage3 <= stage2;
			LEVEL <= next_level;
		end
	end
endmodule : pin_sync

// ==== hw/entry_host.sv ====
// Purpose: Host end that issues the four-cycle register entry sequence.
// Assumes: One request at a time; CLK far faster than the bus cycles.
// Notes: Each cycle raises select for a gap so the memory counts it separately.
`timescale 1ns/1ps
module entry_host
(
	// Clock and reset
	input wire logic CLK,
	input wire logic RST,
	// User request
	input wire logic START,
	input wire logic IS_WRITE,
	input wire logic [entry_pkg::DATA_W-1:0] SELECT_VALUE,
	input wire logic [entry_pkg::DATA_W-1:0] WRITE_DATA,
	output logic BUSY,
	output logic DONE,
	output logic [entry_pkg::DATA_W-1:0] READ_DATA,
	// Bus
	entry_if.host bus
);
	import entry_pkg::*;
	typedef enum logic [1:0] {H_IDLE = 2'b00, H_LOW = 2'b01, H_GAP = 2'b11} hstate_type;
	hstate_type state;
	hstate_type next_state;
	logic [1:0] step;
	logic [1:0] next_step;
	logic [3:0] count;
	logic [3:0] next_count;
	logic wr;
	logic next_wr;
	logic [DATA_W-1:0] sel;
	logic [DATA_W-1:0] next_sel;
	logic [DATA_W-1:0] wdata;
	logic [DATA_W-1:0] next_wdata;
	logic [DATA_W-1:0] next_read;
	logic next_done;
	logic cycle_write;

	// Steps 0 and 1 read, step 2 writes the selector, step 3 is the user's access.
	assign cycle_write = (step == 2'd2) || (step == 2'd3 && wr);

	always_comb
	begin
		next_state = state;
		next_step = step;
		next_count = count;
		next_wr = wr;
		next_sel = sel;
		next_wdata = wdata;
		next_read = READ_DATA;
		next_done = 1'b0;
		unique case (state)
			H_IDLE:
			begin
				if (START)
				begin
					next_state = H_LOW;
					next_step = 2'd0;
					next_count = 4'h0;
					next_wr = IS_WRITE;
					next_sel = SELECT_VALUE;
					next_wdata = WRITE_DATA;
				end
			end
			H_LOW:
			begin
				next_count = count + 4'h1;
				if (count == ACCESS_CYCLES - 4'h1)
				begin
					next_state = H_GAP;
					next_count = 4'h0;
					if (step == 2'd3 && !wr)
					begin
						next_read = bus.dq_in;
					end
				end
			end
			H_GAP:
			begin
				next_count = count + 4'h1;
				if (count == GAP_CYCLES - 4'h1)
				begin
					next_count = 4'h0;
					if (step == 2'd3)
					begin
						next_state = H_IDLE;
						next_done = 1'b1;
					end
					else
					begin
						next_state = H_LOW;
						next_step = step + 2'd1;
					end
				end
			end
		endcase
	end

	always_ff @(posedge CLK)
	begin
		if (RST)
		begin
			state <= H_IDLE;
			step <= 2'd0;
			count <= 4'h0;
			wr <= 1'b0;
			sel <= '0;
			wdata <= '0;
			READ_DATA <= '0;
			DONE <= 1'b0;
		end
		else
		begin
			state <= next_state;
			step <= next_step;
			count <= next_count;
			wr <= next_wr;
			sel <= next_sel;
			wdata <= next_wdata;
			READ_DATA <= next_read;
			DONE <= next_done;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	assign BUSY = (state != H_IDLE);
	// Select toggles every cycle; address held all ones throughout.
	assign bus.select_n = (state != H_LOW);
	assign bus.addr = TOP_ADDR;
	assign bus.address_valid_n = 1'b0;
	// Plain asynchronous timing with the clock parked low.
	assign bus.bus_clk = 1'b0;
	assign bus.write_n = !(state == H_LOW && cycle_write);
	assign bus.output_en_n = !(state == H_LOW && !cycle_write);
	// Selector in cycle three, payload in cycle four.
	assign bus.host_dq_out = (step == 2'd2) ? sel : wdata;
	assign bus.host_dq_oe_n = !(state == H_LOW && cycle_write);
endmodule : entry_host

// ==== hw/entry_mem.sv ====
// Purpose: Memory end that detects the four-cycle register entry sequence.
// Assumes: Array accesses outside the sequence are served elsewhere.
// Notes: A cycle is counted when select rises after being low.
`timescale 1ns/1ps

// Operation
// - Four cycles, all at the all-ones address.
// - First two cycles are back-to-back reads.
// - Third cycle writes top, picks the register.
// - Fourth write loads register; fourth read drives it.
// - Register read-back is supported.
// - Values come from the sixteen data lines.
// - Only low sixteen of twenty-two bits reachable.
// - Host uses asynchronous timing only.
// - Host holds clock low throughout.
// - Selector 00 refresh, 01 bus, 02 identification.
// - Any other order or count fails entry.
// - Host toggles select between cycles.
// - Host holds the top address each cycle.
module entry_mem
(
	// Clock and reset
	input wire logic CLK,
	input wire logic RST,
	// Bus
	entry_if.mem bus,
	// Register contents and status
	output logic [entry_pkg::REG_W-1:0] REFRESH_CONFIG,
	output logic [entry_pkg::REG_W-1:0] BUS_CONFIG,
	output logic REGISTER_MODE,
	output logic ENTRY_DONE
);
	import entry_pkg::*;
	logic sel_n;
	logic wr_n;
	logic oe_n;
	logic [ADDR_W-1:0] addr_s;
	logic [DATA_W-1:0] dq_s;
	logic sel_prev;
	logic cyc_write;
	logic cyc_top;
	logic next_cyc_write;
	logic next_cyc_top;
	logic [DATA_W-1:0] cyc_data;
	logic [DATA_W-1:0] next_cyc_data;
	logic cyc_end;
	det_state_type state;
	det_state_type next_state;
	target_type target;
	target_type next_target;
	logic [REG_W-1:0] refresh_config_reg;
	logic [REG_W-1:0] bus_config_reg;
	logic [REG_W-1:0] next_refresh;
	logic [REG_W-1:0] next_bus;
	logic next_done;
	logic [DATA_W-1:0] read_value;
	logic [DATA_W-1:0] dq_out;
	logic [DATA_W-1:0] next_dq_out;

	pin_sync #(.W(3), .INIT(3'b111)) ctl_sync (
		.CLK(CLK),
		.RST(RST),
		.PIN({bus.select_n, bus.write_n, bus.output_en_n}),
		.LEVEL({sel_n, wr_n, oe_n})
	);
	// Address and data are filtered apart: the data lines wander while nobody drives them.
	// A shared filter would then never agree and would hold the address at its reset value.
	pin_sync #(.W(ADDR_W)) addr_sync (
		.CLK(CLK),
		.RST(RST),
		.PIN(bus.addr),
		.LEVEL(addr_s)
	);
	pin_sync #(.W(DATA_W)) dq_sync (
		.CLK(CLK),
		.RST(RST),
		.PIN(bus.dq_in),
		.LEVEL(dq_s)
	);

	////////////////////////////////////////////////////////////////////////////
	// Capture the cycle kind while select is low; a write on any sample after the first low one counts.
	assign cyc_end = sel_n && !sel_prev;

	always_comb
	begin
		next_cyc_write = cyc_write;
		next_cyc_top = cyc_top;
		next_cyc_data = cyc_data;
		if (!sel_n && sel_prev)
		begin
			next_cyc_write = 1'b0;
			next_cyc_top = 1'b1;
		end
		else if (!sel_n)
		begin
			if (!wr_n)
			begin
				next_cyc_write = 1'b1;
				next_cyc_data = dq_s;
			end
			if (addr_s != TOP_ADDR)
			begin
				next_cyc_top = 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Sequence detector; any deviation falls back to idle or a fresh first read.
	always_comb
	begin
		next_state = state;
		next_target = target;
		next_refresh = refresh_config_reg;
		next_bus = bus_config_reg;
		next_done = 1'b0;
		if (cyc_end)
		begin
			unique case (state)
				DET_IDLE, DET_READ1, DET_READ2:
				begin
					if (cyc_top && !cyc_write && state != DET_READ2)
					begin
						next_state = (state == DET_IDLE) ? DET_READ1 : DET_READ2;
					end
					else if (cyc_top && cyc_write && state == DET_READ2)
					begin
						next_state = DET_FINAL;
						next_target = decode_target(cyc_data);
					end
					else
					begin
						next_state = (cyc_top && !cyc_write) ? DET_READ1 : DET_IDLE;
					end
				end
				DET_FINAL:
				begin
					if (cyc_top && cyc_write)
					begin
						// Upper six bits keep their value.
						if (target == TGT_REFRESH)
						begin
							next_refresh = {refresh_config_reg[REG_W-1:DATA_W], cyc_data};
						end
						if (target == TGT_BUS)
						begin
							next_bus = {bus_config_reg[REG_W-1:DATA_W], cyc_data};
						end
					end
					next_done = cyc_top;
					next_state = DET_IDLE;
				end
				default:
				begin
					next_state = DET_IDLE;
				end
			endcase
		end
	end

	// Read-back of the selected register's low sixteen bits.
	always_comb
	begin
		unique case (target)
			TGT_REFRESH: read_value = refresh_config_reg[DATA_W-1:0];
			TGT_BUS: read_value = bus_config_reg[DATA_W-1:0];
			TGT_IDENT: read_value = IDENT_VALUE[DATA_W-1:0];
			TGT_NONE: read_value = '0;
		endcase
	end

	assign next_dq_out = read_value;

	always_ff @(posedge CLK)
	begin
		if (RST)
		begin
			sel_prev <= 1'b1;
			cyc_write <= 1'b0;
			cyc_top <= 1'b0;
			cyc_data <= '0;
			state <= DET_IDLE;
			target <= TGT_NONE;
			refresh_config_reg <= REFRESH_RESET;
			bus_config_reg <= BUS_RESET;
			ENTRY_DONE <= 1'b0;
			dq_out <= '0;
		end
		else
		begin
			sel_prev <= sel_n;
			cyc_write <= next_cyc_write;
			cyc_top <= next_cyc_top;
			cyc_data <= next_cyc_data;
			state <= next_state;
			target <= next_target;
			refresh_config_reg <= next_refresh;
			bus_config_reg <= next_bus;
			ENTRY_DONE <= next_done;
			dq_out <= next_dq_out;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Drives only during a fourth-cycle read; the latency of the synchronisers limits speed.
	assign REGISTER_MODE = (state == DET_FINAL);
	assign REFRESH_CONFIG = refresh_config_reg;
	assign BUS_CONFIG = bus_config_reg;
	assign bus.mem_dq_out = dq_out;
	assign bus.mem_dq_oe_n = !(state == DET_FINAL && !sel_n && !oe_n && wr_n);
endmodule : entry_mem

// ==== test/entry_props.sv ====
// Purpose: Protocol checks on the entry bus between the host and memory ends.
// Assumes: All signals sampled on CLK; RST synchronous, active high.
// Notes: Register contents are judged by the testbench, not here.
`timescale 1ns/1ps
module entry_props
(
	// Clock and reset
	input wire logic CLK,
	input wire logic RST,
	// Bus controls
	input wire logic select_n,
	input wire logic write_n,
	input wire logic output_en_n,
	input wire logic address_valid_n,
	input wire logic bus_clk,
	input wire logic [entry_pkg::ADDR_W-1:0] addr,
	// Data enables
	input wire logic host_dq_oe_n,
	input wire logic mem_dq_oe_n
);
	import entry_pkg::*;
	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (RST);
	clock_low_a: assert property (bus_clk == 1'b0) else $error("bus clock moved");
	top_addr_a: assert property (!select_n |-> addr == TOP_ADDR) else $error("address not top");
	latch_open_a: assert property (!select_n |-> !address_valid_n) else $error("address latch closed");
	access_len_a: assert property ($fell(select_n) |-> !select_n [*6] ##1 select_n) else $error("bad access length");
	gap_len_a: assert property ($rose(select_n) |-> select_n [*2]) else $error("select gap too short");
	one_dir_a: assert property (!(write_n == 1'b0 && output_en_n == 1'b0)) else $error("read and write together");
	no_fight_a: assert property (!(host_dq_oe_n == 1'b0 && mem_dq_oe_n == 1'b0)) else $error("both ends drive data");
	strobe_in_a: assert property ((!write_n || !output_en_n) |-> !select_n) else $error("strobe outside select");
	mem_read_a: assert property (!mem_dq_oe_n |-> write_n) else $error("memory drives during write");
	cover property ($fell(write_n));
	cover property ($fell(mem_dq_oe_n));
	cover property ($fell(select_n));
endmodule : entry_props

// ==== test/sw_register_entry_detector_tb_top.sv ====
// Purpose: Self-checking bench joining the host and memory ends of the entry bus.
// Assumes: Clock 50 MHz; reset held two cycles.
// Notes: A second memory is driven by hand to try orders the host never makes.
`timescale 1ns/1ps
module sw_register_entry_detector_tb_top;
	import entry_pkg::*;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic start = 1'b0;
	logic is_write = 1'b0;
	logic [15:0] sel = 16'h0000;
	logic [15:0] wdata = 16'h0000;
	logic busy, done, reg_mode, entry_done, mode2;
	logic [15:0] rdata;
	logic [21:0] refresh, buscfg, refresh2;
	int err_total = 0;
	int n_compared = 0;
	int cyc = 0;
	int done_seen = 0;
	entry_if bus ();
	entry_if bus2 ();
	// A released data line shows a changing pattern, never the last value.
	assign bus.dq_in = !bus.host_dq_oe_n ? bus.host_dq_out : !bus.mem_dq_oe_n ? bus.mem_dq_out : 16'hA5A5 ^ {16{cyc[0]}};
	assign bus2.dq_in = !bus2.host_dq_oe_n ? bus2.host_dq_out : !bus2.mem_dq_oe_n ? bus2.mem_dq_out : 16'h5A5A ^ {16{cyc[0]}};
	entry_host entry_host_inst (.CLK(clk), .RST(rst), .START(start), .IS_WRITE(is_write), .SELECT_VALUE(sel),
		.WRITE_DATA(wdata), .BUSY(busy), .DONE(done), .READ_DATA(rdata), .bus(bus.host));
	entry_mem entry_mem_inst (.CLK(clk), .RST(rst), .bus(bus.mem), .REFRESH_CONFIG(refresh), .BUS_CONFIG(buscfg),
		.REGISTER_MODE(reg_mode), .ENTRY_DONE(entry_done));
	entry_mem entry_mem_inst2 (.CLK(clk), .RST(rst), .bus(bus2.mem), .REFRESH_CONFIG(refresh2), .BUS_CONFIG(),
		.REGISTER_MODE(mode2), .ENTRY_DONE());
	entry_props entry_props_inst (.CLK(clk), .RST(rst), .select_n(bus.select_n), .write_n(bus.write_n),
		.output_en_n(bus.output_en_n), .address_valid_n(bus.address_valid_n), .bus_clk(bus.bus_clk),
		.addr(bus.addr), .host_dq_oe_n(bus.host_dq_oe_n), .mem_dq_oe_n(bus.mem_dq_oe_n));
	always #10 clk = ~clk;
	////////////////////////////////////////////////////////////////////////////////
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (entry_done === 1'b1)
		begin
			done_seen <= done_seen + 1;
		end
		// Ceiling well above the nine sequences the run makes.
		if (cyc > 3000)
		begin
			err_total++;
			report_and_stop();
		end
	end
	task automatic report_and_stop();
		$display("compared %0d mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0)
		begin
			$display("Regression OK");
		end
		else
		begin
			$display("Regression broken");
		end
		$finish;
	endtask : report_and_stop
	task automatic chk(input string what, input logic [21:0] exp, input logic [21:0] got);
		n_compared++;
		if (got !== exp)
		begin
			err_total++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic run_seq(input logic wr, input logic [15:0] s, input logic [15:0] d);
		int n;
		n = 0;
		@(posedge clk);
		start <= 1'b1;
		is_write <= wr;
		sel <= s;
		wdata <= d;
		@(posedge clk);
		start <= 1'b0;
		@(negedge clk);
		chk("busy", 1'b1, busy);
		while (done !== 1'b1 && n < 60)
		begin
			@(negedge clk);
			n++;
		end
		chk("done", 1'b1, done);
		chk("idle", 1'b0, busy);
		repeat (10) @(negedge clk);
	endtask : run_seq
	task automatic cyc2(input logic wr, input logic [15:0] d);
		@(posedge clk);
		bus2.select_n <= 1'b0;
		bus2.write_n <= !wr;
		bus2.output_en_n <= wr;
		bus2.host_dq_oe_n <= !wr;
		bus2.host_dq_out <= d;
		repeat (4) @(posedge clk);
		bus2.select_n <= 1'b1;
		bus2.write_n <= 1'b1;
		bus2.output_en_n <= 1'b1;
		bus2.host_dq_oe_n <= 1'b1;
		@(posedge clk);
	endtask : cyc2
	////////////////////////////////////////////////////////////////////////////////
	task automatic t_program();
		run_seq(1'b1, SEL_REFRESH, 16'hBEEF);
		chk("refresh", 22'h00_BEEF, refresh);
		chk("bus", BUS_RESET, buscfg);
		run_seq(1'b1, SEL_BUS, 16'h5A3C);
		chk("bus", 22'h00_5A3C, buscfg);
		chk("done count", 22'h00_0002, 22'(done_seen));
		chk("mode", 1'b0, reg_mode);
	endtask : t_program
	task automatic t_readback();
		run_seq(1'b0, SEL_REFRESH, 16'h0000);
		chk("read refresh", 22'h00_BEEF, rdata);
		run_seq(1'b0, SEL_BUS, 16'h0000);
		chk("read bus", 22'h00_5A3C, rdata);
		run_seq(1'b0, SEL_IDENT, 16'h0000);
		chk("read ident", {6'h00, IDENT_VALUE[15:0]}, rdata);
	endtask : t_readback
	task automatic t_bad_select();
		run_seq(1'b1, 16'h0003, 16'hFFFF);
		chk("refresh kept", 22'h00_BEEF, refresh);
		chk("bus kept", 22'h00_5A3C, buscfg);
		run_seq(1'b0, 16'h0003, 16'h0000);
		chk("read none", 22'h00_0000, rdata);
	endtask : t_bad_select
	task automatic t_bad_order();
		cyc2(1'b0, 16'h0000);
		cyc2(1'b1, SEL_REFRESH);
		cyc2(1'b0, 16'h0000);
		cyc2(1'b1, 16'h1111);
		repeat (8) @(negedge clk);
		chk("no entry", REFRESH_RESET, refresh2);
		cyc2(1'b0, 16'h0000);
		cyc2(1'b0, 16'h0000);
		cyc2(1'b1, SEL_REFRESH);
		repeat (5) @(negedge clk);
		chk("mode up", 1'b1, mode2);
		cyc2(1'b1, 16'h2222);
		repeat (8) @(negedge clk);
		chk("entry", 22'h00_2222, refresh2);
		chk("mode down", 1'b0, mode2);
	endtask : t_bad_order
	initial
	begin
		bus2.select_n = 1'b1;
		bus2.write_n = 1'b1;
		bus2.output_en_n = 1'b1;
		bus2.address_valid_n = 1'b0;
		bus2.bus_clk = 1'b0;
		bus2.addr = TOP_ADDR;
		bus2.host_dq_oe_n = 1'b1;
		bus2.host_dq_out = 16'h0000;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		repeat (4) @(posedge clk);
		t_program();
		t_readback();
		t_bad_select();
		t_bad_order();
		report_and_stop();
	end
endmodule : sw_register_entry_detector_tb_top
